// *** rcg_pkg.sv ***
// Constants and types shared by the reset and clock-gating controller.
// Assumes a single 40 MHz core clock and a word-wide register access port.
package rcg_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;

  localparam logic [6:0] ADDR_GCONF = 7'h00;
  localparam logic [6:0] ADDR_EVENT_REGISTER = 7'h0e;
  localparam logic [6:0] ADDR_GDELAY = 7'h14;
  localparam logic [6:0] ADDR_STBY_DELAY = 7'h15;
  localparam logic [6:0] ADDR_GTRIG = 7'h4f;
  localparam logic [6:0] ADDR_START_DELAY = 7'h7c;
  localparam logic [6:0] ADDR_STATUS = 7'h7d;

  localparam logic [31:0] GCONF_RST = 32'h0000_6020;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [2:0] GTRIG_RST = 3'h0;
  localparam int unsigned GCONF_GATE_EN_BIT = 17;
  localparam int unsigned GCONF_STBY_EN_BIT = 18;
  localparam int unsigned EV_RST_BIT = 31;
  localparam int unsigned KEY_LSB = 8;
  localparam logic [23:0] SW_RST_KEY = 24'h52_5354;
  localparam logic [2:0] GTRIG_FIRE = 3'h7;

  // Lead time before the next ramp start at which gating is released
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned WAKE_LEAD_NS = 400;
  localparam logic [31:0] WAKE_LEAD_CYC =
    32'((WAKE_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    GS_IDLE = 3'b001,
    GS_COUNT = 3'b010,
    GS_GATED = 3'b100
  } rcg_gstate_t;

  typedef struct packed {
    logic standby;
    logic counting;
    logic gated;
  } rcg_status_t;

endpackage

// *** rcg_pin_sync.sv ***
// Three-stage synchroniser for a slow pin; the level moves only when the
// second and third stages agree. Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module rcg_pin_sync
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic pin_in, // raw pin
  output logic level_out // filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  always_comb
  begin
    level_d = level_out;
    if (s2_q == s3_q)
    begin
      level_d = s3_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_out <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_out <= level_d;
    end
  end
endmodule
`default_nettype wire

// *** rcg_ctrl.sv ***
// Reset sources, reset event flag, clock-gating sequencer and ramp timers.
// Assumes register accesses arrive synchronous to core_clk_in, one per cycle.
`timescale 1ns/1ps
`default_nettype none
//  Contract
// - Hardware reset pin low returns all registers to defaults.
// - Power-on reset restores all register defaults without host action.
// - Key 0x525354 in bits 31:8 of 0x4F causes software reset.
// - Software reset key is ignored while safety freeze is active.
// - Any reset sets reset event flag, event register bit 31.
// - Gating acts only if enable bit 17 of 0x00 is set first.
// - Counter counts cycles; clock is gated when it reaches zero.
// - Zero gating delay gates clock immediately after trigger.
// - High level on step wake input ends gating.
// - Entering standby with standby-gating enabled starts the delay counter.
// - Standby starts when standby delay expires after ramp stop.
// - Gating is released shortly before the start delay expires.
// - Start delay runs from target reached until next ramp start.
module rcg_ctrl
  import rcg_pkg::*;
(
  input wire logic core_clk_in, // 40 MHz clock
  input wire logic rst_n_in, // power-on reset, active low
  input wire logic hw_reset_n_pin_in, // hardware reset pin, active low
  input wire logic step_wake_input_in, // wake pin, active high
  input wire logic safety_freeze_state_in, // freeze condition
  input wire logic target_reached_in, // ramp stopped, velocity zero
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  input wire logic [ADDR_W-1:0] reg_addr_in, // register address
  input wire logic [DATA_W-1:0] reg_wdata_in, // write data
  output logic [DATA_W-1:0] reg_rdata_out, // read data, one cycle later
  output logic clk_gated_out, // internal clock gated off
  output logic standby_out, // standby phase active
  output logic ramp_start_out, // next ramp start pulse
  output logic regs_reset_out, // register reset pulse to the device
  output logic reset_event_out // reset event flag
);
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction
  logic hw_rst_lvl, wake_lvl;
  logic [31:0] gconf_q, gconf_d, gdelay_q, gdelay_d;
  logic [31:0] stby_delay_q, stby_delay_d, start_delay_q, start_delay_d;
  logic [2:0] gtrig_q, gtrig_d;
  rcg_gstate_t gstate_q, gstate_d;
  logic [31:0] gcnt_q, gcnt_d, stby_cnt_q, stby_cnt_d, start_cnt_q, start_cnt_d;
  logic reset_event_flag_q, reset_event_flag_d, stby_run_q, stby_run_d, standby_d, start_act_q, start_act_d, tr_q;
  logic [DATA_W-1:0] rdata_d;
  logic key_hit, regs_clear, trig_wr, gate_en, stby_en, stby_enter, tr_rise;
  logic wake_by_start, gstart;
  rcg_status_t status;

  rcg_pin_sync #(.RST_VAL(1'b1)) u_rst_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(hw_reset_n_pin_in),
    .level_out(hw_rst_lvl)
  );
  rcg_pin_sync #(.RST_VAL(1'b0)) u_wake_sync (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(step_wake_input_in),
    .level_out(wake_lvl)
  );

  always_comb
  begin
    key_hit = reg_wr_in && hit(reg_addr_in, ADDR_GTRIG)
      && (reg_wdata_in[31:KEY_LSB] == SW_RST_KEY) && !safety_freeze_state_in;
    regs_clear = !hw_rst_lvl || key_hit;
    trig_wr = reg_wr_in && hit(reg_addr_in, ADDR_GTRIG) && (reg_wdata_in[2:0] == GTRIG_FIRE);
    gate_en = gconf_q[GCONF_GATE_EN_BIT];
    stby_en = gconf_q[GCONF_STBY_EN_BIT];
    tr_rise = target_reached_in && !tr_q;
    stby_enter = stby_run_q && (stby_cnt_q == 32'h0000_0000) && target_reached_in;
    wake_by_start = start_act_q && (start_cnt_q == WAKE_LEAD_CYC);
    gstart = gate_en && !wake_lvl && !wake_by_start
      && (trig_wr || (stby_en && stby_enter));
    status.standby = standby_out;
    status.counting = (gstate_q == GS_COUNT);
    status.gated = (gstate_q == GS_GATED);
  end
  // Register file; the event flag set beats a software clear in the same cycle
  always_comb
  begin
    gconf_d = gconf_q;
    gdelay_d = gdelay_q;
    stby_delay_d = stby_delay_q;
    start_delay_d = start_delay_q;
    gtrig_d = gtrig_q;
    reset_event_flag_d = reset_event_flag_q;
    if (reg_wr_in)
    begin
      if (hit(reg_addr_in, ADDR_GCONF))
        gconf_d = reg_wdata_in;
      if (hit(reg_addr_in, ADDR_GDELAY))
        gdelay_d = reg_wdata_in;
      if (hit(reg_addr_in, ADDR_STBY_DELAY))
        stby_delay_d = reg_wdata_in;
      if (hit(reg_addr_in, ADDR_START_DELAY))
        start_delay_d = reg_wdata_in;
      if (hit(reg_addr_in, ADDR_GTRIG))
        gtrig_d = reg_wdata_in[2:0];
      if (hit(reg_addr_in, ADDR_EVENT_REGISTER) && reg_wdata_in[EV_RST_BIT])
        reset_event_flag_d = 1'b0;
    end
    if (regs_clear)
    begin
      gconf_d = GCONF_RST;
      gdelay_d = DELAY_RST;
      stby_delay_d = DELAY_RST;
      start_delay_d = DELAY_RST;
      gtrig_d = GTRIG_RST;
      reset_event_flag_d = 1'b1;
    end
  end

  always_comb
  begin
    rdata_d = '0;
    case (reg_addr_in)
      ADDR_GCONF: rdata_d = gconf_q;
      ADDR_EVENT_REGISTER: rdata_d = {reset_event_flag_q, 31'h0000_0000};
      ADDR_GDELAY: rdata_d = gdelay_q;
      ADDR_STBY_DELAY: rdata_d = stby_delay_q;
      ADDR_GTRIG: rdata_d = {29'h0000_0000, gtrig_q};
      ADDR_START_DELAY: rdata_d = start_delay_q;
      ADDR_STATUS: rdata_d = {29'h0000_0000, status};
      default: rdata_d = '0;
    endcase
  end
  // Gating sequencer
  always_comb
  begin
    gstate_d = gstate_q;
    gcnt_d = gcnt_q;
    if (regs_clear)
    begin
      gstate_d = GS_IDLE;
      gcnt_d = 32'h0000_0000;
    end
    else if ((gstate_q != GS_IDLE) && (wake_lvl || !gate_en || wake_by_start))
      gstate_d = GS_IDLE;
    else if (gstart && (gstate_q != GS_GATED))
    begin
      if (gdelay_q == 32'h0000_0000)
        gstate_d = GS_GATED;
      else
      begin
        gstate_d = GS_COUNT;
        gcnt_d = gdelay_q;
      end
    end
    else
    begin
      case (gstate_q)
        GS_COUNT:
        begin
          if (gcnt_q <= 32'h0000_0001)
            gstate_d = GS_GATED;
          gcnt_d = gcnt_q - 32'h0000_0001;
        end
        GS_IDLE, GS_GATED: gcnt_d = gcnt_q;
        default: gstate_d = GS_IDLE;
      endcase
    end
  end
  // Standby and start delay timers, both armed by the ramp stop edge
  always_comb
  begin
    stby_run_d = stby_run_q;
    stby_cnt_d = stby_cnt_q;
    standby_d = standby_out;
    start_act_d = start_act_q;
    start_cnt_d = start_cnt_q;
    if (!target_reached_in || regs_clear)
    begin
      stby_run_d = 1'b0;
      standby_d = 1'b0;
    end
    else if (tr_rise)
    begin
      stby_run_d = 1'b1;
      stby_cnt_d = stby_delay_q;
    end
    else if (stby_enter)
    begin
      stby_run_d = 1'b0;
      standby_d = 1'b1;
    end
    else if (stby_run_q)
      stby_cnt_d = stby_cnt_q - 32'h0000_0001;
    if (regs_clear)
      start_act_d = 1'b0;
    else if (tr_rise && (start_delay_q != 32'h0000_0000))
    begin
      start_act_d = 1'b1;
      start_cnt_d = start_delay_q;
    end
    else if (start_act_q)
    begin
      start_cnt_d = start_cnt_q - 32'h0000_0001;
      if (start_cnt_q == 32'h0000_0001)
        start_act_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gconf_q <= GCONF_RST;
      gdelay_q <= DELAY_RST;
      stby_delay_q <= DELAY_RST;
      start_delay_q <= DELAY_RST;
      gtrig_q <= GTRIG_RST;
      reset_event_flag_q <= 1'b1;
      gstate_q <= GS_IDLE;
      gcnt_q <= 32'h0000_0000;
      stby_run_q <= 1'b0;
      stby_cnt_q <= 32'h0000_0000;
      start_act_q <= 1'b0;
      start_cnt_q <= 32'h0000_0000;
      tr_q <= 1'b0;
      reg_rdata_out <= '0;
      clk_gated_out <= 1'b0;
      standby_out <= 1'b0;
      ramp_start_out <= 1'b0;
      regs_reset_out <= 1'b1;
      reset_event_out <= 1'b1;
    end
    else
    begin
      gconf_q <= gconf_d;
      gdelay_q <= gdelay_d;
      stby_delay_q <= stby_delay_d;
      start_delay_q <= start_delay_d;
      gtrig_q <= gtrig_d;
      reset_event_flag_q <= reset_event_flag_d;
      gstate_q <= gstate_d;
      gcnt_q <= gcnt_d;
      stby_run_q <= stby_run_d;
      stby_cnt_q <= stby_cnt_d;
      start_act_q <= start_act_d;
      start_cnt_q <= start_cnt_d;
      tr_q <= target_reached_in;
      reg_rdata_out <= reg_rd_in ? rdata_d : reg_rdata_out;
      clk_gated_out <= (gstate_d == GS_GATED);
      standby_out <= standby_d;
      ramp_start_out <= start_act_q && !regs_clear && (start_cnt_q == 32'h0000_0001);
      regs_reset_out <= regs_clear;
      reset_event_out <= reset_event_flag_d;
    end
  end
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic quiet;
  assign quiet = !wake_lvl && !regs_clear && gate_en && !wake_by_start;
  sequence s_trig3;
    gstart && (gstate_q == GS_IDLE) && (gdelay_q == 32'h0000_0003);
  endsequence

  a_key_reset_flag: assert property (key_hit |=> regs_reset_out && reset_event_out)
    else $error("key write did not reset");
  a_freeze_blocks_key: assert property (reg_wr_in && hit(reg_addr_in, ADDR_GTRIG)
    && reg_wdata_in[31:KEY_LSB] == SW_RST_KEY && safety_freeze_state_in && hw_rst_lvl
    |=> !regs_reset_out)
    else $error("key accepted during freeze");
  a_hw_pin_reset: assert property ($fell(hw_rst_lvl) |=> regs_reset_out && gconf_q == GCONF_RST
    && reset_event_out)
    else $error("reset pin ignored");
  a_flag_sticky: assert property (reset_event_out && !(reg_wr_in && hit(reg_addr_in, ADDR_EVENT_REGISTER))
    |=> reset_event_out)
    else $error("reset flag dropped");
  a_gate_needs_en: assert property ((gstate_q == GS_IDLE) && !gate_en |=> !clk_gated_out)
    else $error("gated while disabled");
  a_gate_zero_delay: assert property (gstart && (gstate_q == GS_IDLE) && (gdelay_q == 32'h0)
    |=> clk_gated_out)
    else $error("zero delay did not gate");
  a_gate_count_three: assert property (s_trig3 ##1 (quiet && !gstart)[*3] |=> clk_gated_out
    && !$past(clk_gated_out))
    else $error("gating delay count wrong");
  a_wake_ungates: assert property (wake_lvl |=> !clk_gated_out)
    else $error("wake level did not ungate");
  a_en_clear_ungates: assert property (!gate_en |=> !clk_gated_out)
    else $error("clear enable did not ungate");
  a_standby_gates: assert property (stby_enter && stby_en && quiet && (gdelay_q == 32'h0)
    && (gstate_q == GS_IDLE) |=> clk_gated_out && standby_out)
    else $error("standby did not gate");
  a_start_wake_lead: assert property (wake_by_start |=> !clk_gated_out)
    else $error("gating not released before start");
endmodule
`default_nettype wire

// *** rcg_host.sv ***
// Host model: drives the two pins and the word-wide register port.
// Assumes every task is entered just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rcg_host
  import rcg_pkg::*;
(
  input wire logic clk_in, // core clock
  input wire logic [DATA_W-1:0] rdata_in, // read data
  output logic rst_pin_n_out, // hardware reset pin
  output logic wake_out, // step wake pin
  output logic wr_out, // write strobe
  output logic rd_out, // read strobe
  output logic [ADDR_W-1:0] addr_out, // register address
  output logic [DATA_W-1:0] wdata_out // write data
);
  initial
  begin
    rst_pin_n_out = 1'b1;
    wake_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = '0;
    wdata_out = '0;
  end
  task automatic pins(input logic rst_n, input logic wake);
    rst_pin_n_out = rst_n;
    wake_out = wake;
  endtask
  // Idle cycle after each access, so a strobe never drops and rises at once
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    wdata_out = ~d;
    @(posedge clk_in);
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// *** rcg_ctrl_bench.sv ***
// Self-checking bench for the reset and clock-gating controller.
// Assumes the host model owns the register port and both pins.
`timescale 1ns/1ps
`default_nettype none
module rcg_ctrl_bench
  import rcg_pkg::*;
;
  logic clk, rst_n, frz, tgt, pin_n, wake, wr, rd;
  logic gated, stby, rstart, rreset, rev, g, seen_rr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  rcg_ctrl u_rcg_ctrl (.core_clk_in(clk), .rst_n_in(rst_n), .hw_reset_n_pin_in(pin_n),
    .step_wake_input_in(wake), .safety_freeze_state_in(frz), .target_reached_in(tgt),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .clk_gated_out(gated), .standby_out(stby),
    .ramp_start_out(rstart), .regs_reset_out(rreset), .reset_event_out(rev));
  rcg_host u_rcg_host (.clk_in(clk), .rdata_in(rdata), .rst_pin_n_out(pin_n),
    .wake_out(wake), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A pulse this short is easy to miss by sampling, so it is latched
  always @(posedge clk)
  begin
    cyc++;
    if (rreset === 1'b1)
      seen_rr <= 1'b1;
    if (cyc == 2000)
    begin
      err_count++;
      $display("[FAIL] timeout expected done seen hung");
      complete_run();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    frz = 1'b0;
    tgt = 1'b0;
    seen_rr = 1'b0;
    tick(3);
    rst_n = 1'b1;
    chk("reset_event", 32'h0000_0001, 32'(rev));
    u_rcg_host.rd(ADDR_GCONF, v);
    chk("gconf", GCONF_RST, v);
    u_rcg_host.rd(ADDR_GDELAY, v);
    chk("gdelay", DELAY_RST, v);
    u_rcg_host.rd(7'h33, v);
    chk("unmapped", 32'h0000_0000, v);
    u_rcg_host.wr(ADDR_EVENT_REGISTER, 32'h8000_0000);
    chk("reset_event", 32'h0000_0000, 32'(rev));
    // Trigger without the enable bit must not gate
    u_rcg_host.wr(ADDR_GTRIG, 32'h0000_0007);
    tick(4);
    chk("clk_gated", 32'h0000_0000, 32'(gated));
    u_rcg_host.rd(ADDR_GTRIG, v);
    chk("gtrig", 32'h0000_0007, v);
    // Target reached is held low (ramp not stopped) during every manual trigger
    u_rcg_host.wr(ADDR_GCONF, 32'h0002_6020);
    u_rcg_host.wr(ADDR_GDELAY, 32'h0000_0003);
    u_rcg_host.wr(ADDR_GTRIG, 32'h0000_0007);
    tick(1);
    chk("clk_gated", 32'h0000_0000, 32'(gated));
    tick(1);
    chk("clk_gated", 32'h0000_0001, 32'(gated));
    u_rcg_host.rd(ADDR_STATUS, v);
    chk("status", 32'h0000_0001, v);
    u_rcg_host.pins(1'b1, 1'b1);
    g = 1'b1;
    for (int i = 0; i < 8 && g; i++)
    begin
      tick(1);
      g = gated;
    end
    chk("clk_gated", 32'h0000_0000, 32'(gated));
    u_rcg_host.pins(1'b1, 1'b0);
    tick(6);
    u_rcg_host.wr(ADDR_GDELAY, 32'h0000_0000);
    u_rcg_host.wr(ADDR_GTRIG, 32'h0000_0007);
    chk("clk_gated", 32'h0000_0001, 32'(gated));
    u_rcg_host.wr(ADDR_GDELAY, 32'hFFFF_FFFF);
    u_rcg_host.wr(ADDR_GTRIG, 32'h0000_0000);
    u_rcg_host.wr(ADDR_GTRIG, 32'h0000_0007);
    u_rcg_host.wr(ADDR_GCONF, 32'h0000_6020);
    chk("clk_gated", 32'h0000_0000, 32'(gated));
    u_rcg_host.rd(ADDR_STATUS, v);
    chk("status", 32'h0000_0000, v);
    u_rcg_host.wr(ADDR_GCONF, 32'h0002_6020);
    frz = 1'b1;
    seen_rr = 1'b0;
    u_rcg_host.wr(ADDR_GTRIG, {SW_RST_KEY, 8'h00});
    chk("regs_reset", 32'h0000_0000, 32'(seen_rr));
    u_rcg_host.rd(ADDR_GCONF, v);
    chk("gconf", 32'h0002_6020, v);
    frz = 1'b0;
    u_rcg_host.wr(ADDR_GTRIG, {SW_RST_KEY, 8'h00});
    tick(1);
    chk("regs_reset", 32'h0000_0001, 32'(seen_rr));
    chk("reset_event", 32'h0000_0001, 32'(rev));
    u_rcg_host.rd(ADDR_GCONF, v);
    chk("gconf", GCONF_RST, v);
    u_rcg_host.wr(ADDR_EVENT_REGISTER, 32'h8000_0000);
    u_rcg_host.wr(ADDR_GCONF, 32'h0002_6020);
    u_rcg_host.pins(1'b0, 1'b0);
    tick(6);
    chk("regs_reset", 32'h0000_0001, 32'(rreset));
    u_rcg_host.pins(1'b1, 1'b0);
    tick(6);
    chk("reset_event", 32'h0000_0001, 32'(rev));
    u_rcg_host.rd(ADDR_GCONF, v);
    chk("gconf", GCONF_RST, v);
    u_rcg_host.wr(ADDR_GCONF, 32'h0006_6020);
    u_rcg_host.wr(ADDR_STBY_DELAY, 32'h0000_0002);
    u_rcg_host.wr(ADDR_GDELAY, 32'h0000_0000);
    u_rcg_host.wr(ADDR_START_DELAY, 32'h0000_0028);
    g = 1'b0;
    tgt = 1'b1;
    tick(1);
    for (int i = 1; i <= 40; i++)
    begin
      tick(1);
      g = g | gated;
      if (i == 2 || i == 3)
        chk("standby", 32'(i == 3), 32'(stby));
      if (i == 24 || i == 25)
        chk("clk_gated", 32'(i == 24), 32'(gated));
      if (i == 39)
        chk("ramp_start", 32'h0000_0000, 32'(rstart));
    end
    chk("ramp_start", 32'h0000_0001, 32'(rstart));
    chk("clk_gated", 32'h0000_0000, 32'(gated));
    chk("gated_seen", 32'h0000_0001, 32'(g));
    complete_run();
  end
endmodule
`default_nettype wire
